// ===== core/rcm_pkg.sv
package rcm_pkg;

  // ****************************************************************
  // field layout of the threshold, nominal, qualify and window words
  // ****************************************************************
  localparam int LOS_ACC_LSB = 16;
  localparam int LOS_ACC_MSB = 28;
  localparam int LOS_REJ_LSB = 0;
  localparam int LOS_REJ_MSB = 12;
  localparam int LOS_NOM_W = 13;
  localparam int LOS_GOOD_LSB = 4;
  localparam int LOS_FAIL_LSB = 0;
  localparam int LOS_TIMES_W = 4;
  localparam int LOS_DIV_LSB = 3;
  localparam int LOS_DIV_W = 5;
  localparam int LOS_MASK_BIT = 0;
  localparam int ACT_MASK_BIT = 20;
  localparam int ACT_DIV_LSB = 0;
  localparam int ACT_DIV_W = 19;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic LOS_STS_RST = 1'h1;
  localparam logic ACT_STS_RST = 1'h1;
  localparam logic ACT_EVT_RST = 1'h1;
  localparam logic REF_INVALID_RST = 1'h1;

  // ****************************************************************
  // timing: the activity window is about 10 ms of system clock
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACT_WINDOW_MS = 10;
  localparam int ACT_WINDOW_CYC = ACT_WINDOW_MS * 1000000 / CLK_PERIOD_NS;
  localparam int ACT_ACC_CYC = ACT_WINDOW_CYC / 100;
  localparam int ACT_REJ_CYC = ACT_WINDOW_CYC / 10;

  // ****************************************************************
  // counter widths
  // ****************************************************************
  localparam int LOS_CNT_W = 16;
  localparam int ACT_CNT_W = 24;
  localparam int ACT_DIV_RSVD = 19'h7FFFF;

endpackage

// ===== core/rcm_monitor.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - accept when count within nominal plus/minus accept
// RULE2 - reject when count outside nominal plus/minus reject
// RULE3 - loss compares against 13-bit nominal count
// RULE4 - zero nominal disables loss, status held set
// RULE5 - software sets loss mask with zero nominal
// RULE6 - software soft-resets activity unit while reprogramming
// RULE7 - activity status reads 1 disqualified, resets 1
// RULE8 - event sticky while disqualified, write-one clears
// RULE9 - clear ignored while disqualified persists
// RULE10 - event set out of reset, software clears
// RULE11 - activity mask bit keeps activity status out of reference invalid
// RULE12 - software sets activity divider near 100Hz
// RULE13 - divider zero means one; 0x7FFFF reserved
// RULE14 - loss status uses good/fail counts, zero=one
// RULE15 - loss window is one divided clock period
// RULE16 - reference invalid when unmasked monitor disqualifies
// RULE17 - one activity window qualifies or disqualifies
// RULE18 - neutral window leaves status and counters unchanged
module rcm_monitor #(
  parameter int ACT_NOM = rcm_pkg::ACT_WINDOW_CYC,
  parameter int ACT_ACC = rcm_pkg::ACT_ACC_CYC,
  parameter int ACT_REJ = rcm_pkg::ACT_REJ_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ref_clk_i,
  input wire logic [31:0] loss_threshold_config_i,
  input wire logic [31:0] loss_nominal_config_i,
  input wire logic [7:0] loss_qualify_config_i,
  input wire logic [15:0] loss_window_config_i,
  input wire logic [31:0] activity_window_config_i,
  input wire logic activity_unit0_soft_reset_i,
  input wire logic activity_event_clear_i,
  output logic loss_status_o,
  output logic activity_status_o,
  output logic activity_event_o,
  output logic ref_invalid_o
);

  // ****************************************************************
  // field extraction
  // ****************************************************************
  logic [rcm_pkg::LOS_NOM_W-1:0] los_acc;
  logic [rcm_pkg::LOS_NOM_W-1:0] los_rej;
  logic [rcm_pkg::LOS_NOM_W-1:0] los_nom;
  logic [rcm_pkg::LOS_TIMES_W-1:0] los_good_times;
  logic [rcm_pkg::LOS_TIMES_W-1:0] los_fail_times;
  logic [rcm_pkg::LOS_DIV_W-1:0] los_div;
  logic los_mask;
  logic act_mask;
  logic [rcm_pkg::ACT_DIV_W-1:0] act_div;

  assign los_acc = loss_threshold_config_i[rcm_pkg::LOS_ACC_MSB:
                                           rcm_pkg::LOS_ACC_LSB];
  assign los_rej = loss_threshold_config_i[rcm_pkg::LOS_REJ_MSB:
                                           rcm_pkg::LOS_REJ_LSB];
  assign los_nom = loss_nominal_config_i[rcm_pkg::LOS_NOM_W-1:0]; // [RULE3]
  assign los_good_times = loss_qualify_config_i[
    rcm_pkg::LOS_GOOD_LSB +: rcm_pkg::LOS_TIMES_W];
  assign los_fail_times = loss_qualify_config_i[
    rcm_pkg::LOS_FAIL_LSB +: rcm_pkg::LOS_TIMES_W];
  assign los_div = loss_window_config_i[
    rcm_pkg::LOS_DIV_LSB +: rcm_pkg::LOS_DIV_W];
  assign los_mask = loss_window_config_i[rcm_pkg::LOS_MASK_BIT];
  assign act_mask = activity_window_config_i[rcm_pkg::ACT_MASK_BIT];
  assign act_div = activity_window_config_i[
    rcm_pkg::ACT_DIV_LSB +: rcm_pkg::ACT_DIV_W];

  // ****************************************************************
  // monitored clock edge detection
  // ****************************************************************
  logic ref_prev_ff;
  logic ref_rise;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ref_prev_ff <= 1'h0;
    end else begin
      ref_prev_ff <= ref_clk_i;
    end
  end

  assign ref_rise = ref_clk_i & ~ref_prev_ff;

  // ****************************************************************
  // loss window: divided monitored clock
  // ****************************************************************
  logic [rcm_pkg::LOS_DIV_W-1:0] los_div_cnt_ff;
  logic [rcm_pkg::LOS_DIV_W-1:0] los_div_last;
  logic los_tick;

  // zero and one both divide by one
  assign los_div_last = (los_div == 5'h00) ? 5'h00 : los_div - 5'h01;
  assign los_tick = ref_rise && (los_div_cnt_ff >= los_div_last); // [RULE15]

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      los_div_cnt_ff <= '0;
    end else if (los_tick) begin
      los_div_cnt_ff <= '0;
    end else if (ref_rise) begin
      los_div_cnt_ff <= los_div_cnt_ff + 5'h01;
    end
  end

  // ****************************************************************
  // loss window: system clock period counter
  // ****************************************************************
  logic [rcm_pkg::LOS_CNT_W-1:0] los_cnt_ff;
  logic los_armed_ff;

  // saturates so a very slow reference still lands as rejected
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      los_cnt_ff <= '0;
    end else if (los_tick) begin
      los_cnt_ff <= 16'h0001;
    end else if (los_cnt_ff != 16'hFFFF) begin
      los_cnt_ff <= los_cnt_ff + 16'h0001;
    end
  end

  // the first tick only opens a window; there is no count to judge yet
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      los_armed_ff <= 1'h0;
    end else if (los_tick) begin
      los_armed_ff <= 1'h1;
    end
  end

  // ****************************************************************
  // loss window classification
  // ****************************************************************
  logic [rcm_pkg::LOS_CNT_W:0] los_dev;
  logic los_accept;
  logic los_reject;

  always_comb begin
    if (los_cnt_ff >= {3'h0, los_nom}) begin
      los_dev = {1'h0, los_cnt_ff} - {4'h0, los_nom};
    end else begin
      los_dev = {4'h0, los_nom} - {1'h0, los_cnt_ff};
    end
  end

  assign los_accept = los_tick && los_armed_ff &&
                      (los_dev <= {4'h0, los_acc}); // [RULE1]
  assign los_reject = los_tick && los_armed_ff &&
                      (los_dev > {4'h0, los_rej}); // [RULE2]

  // ****************************************************************
  // loss qualification counters and status
  // ****************************************************************
  logic [rcm_pkg::LOS_TIMES_W-1:0] los_good_ff;
  logic [rcm_pkg::LOS_TIMES_W-1:0] los_fail_ff;
  logic [rcm_pkg::LOS_TIMES_W-1:0] good_need;
  logic [rcm_pkg::LOS_TIMES_W-1:0] fail_need;
  logic los_sts_ff;
  logic los_disabled;

  assign good_need = (los_good_times == 4'h0) ? 4'h1 : los_good_times;
  assign fail_need = (los_fail_times == 4'h0) ? 4'h1 : los_fail_times;
  assign los_disabled = (los_nom == 13'h0000); // [RULE4]

  // reject is checked first: a window with acc > rej margins may be both
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      los_good_ff <= '0;
      los_fail_ff <= '0;
      los_sts_ff <= rcm_pkg::LOS_STS_RST;
    end else if (los_disabled) begin
      los_good_ff <= '0;
      los_fail_ff <= '0;
      los_sts_ff <= 1'h1; // [RULE4]
    end else if (los_reject) begin
      los_good_ff <= '0; // [RULE14]
      if (los_fail_ff + 4'h1 >= fail_need) begin
        los_fail_ff <= '0;
        los_sts_ff <= 1'h1; // [RULE14]
      end else begin
        los_fail_ff <= los_fail_ff + 4'h1;
      end
    end else if (los_accept) begin
      if (los_good_ff + 4'h1 >= good_need) begin
        los_good_ff <= '0;
        los_fail_ff <= '0;
        los_sts_ff <= 1'h0; // [RULE14]
      end else begin
        los_good_ff <= los_good_ff + 4'h1;
      end
    end
    // neither accepted nor rejected: nothing moves [RULE18]
  end

  // ****************************************************************
  // activity window: divided monitored clock
  // ****************************************************************
  logic [rcm_pkg::ACT_DIV_W-1:0] act_div_cnt_ff;
  logic [rcm_pkg::ACT_DIV_W-1:0] act_div_last;
  logic act_tick;
  logic act_srst;

  // the reserved divider value is not trapped; behaviour is undefined
  assign act_div_last = (act_div == 19'h00000) ? 19'h00000
                        : act_div - 19'h00001; // [RULE13]
  assign act_tick = ref_rise && (act_div_cnt_ff >= act_div_last);
  // soft reset holds the unit idle while software reprograms it
  assign act_srst = activity_unit0_soft_reset_i; // [RULE6]

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_div_cnt_ff <= '0;
    end else if (act_srst || act_tick) begin
      act_div_cnt_ff <= '0;
    end else if (ref_rise) begin
      act_div_cnt_ff <= act_div_cnt_ff + 19'h00001;
    end
  end

  // ****************************************************************
  // activity window: system clock period counter
  // ****************************************************************
  logic [rcm_pkg::ACT_CNT_W-1:0] act_cnt_ff;
  logic act_armed_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_cnt_ff <= '0;
    end else if (act_srst) begin
      act_cnt_ff <= '0;
    end else if (act_tick) begin
      act_cnt_ff <= 24'h000001;
    end else if (act_cnt_ff != 24'hFFFFFF) begin
      act_cnt_ff <= act_cnt_ff + 24'h000001;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_armed_ff <= 1'h0;
    end else if (act_srst) begin
      act_armed_ff <= 1'h0;
    end else if (act_tick) begin
      act_armed_ff <= 1'h1;
    end
  end

  // ****************************************************************
  // activity classification and status
  // ****************************************************************
  localparam logic [rcm_pkg::ACT_CNT_W:0] ACT_NOM_W =
    (rcm_pkg::ACT_CNT_W+1)'(ACT_NOM);
  localparam logic [rcm_pkg::ACT_CNT_W:0] ACT_ACC_W =
    (rcm_pkg::ACT_CNT_W+1)'(ACT_ACC);
  localparam logic [rcm_pkg::ACT_CNT_W:0] ACT_REJ_W =
    (rcm_pkg::ACT_CNT_W+1)'(ACT_REJ);

  logic [rcm_pkg::ACT_CNT_W:0] act_dev;
  logic act_accept;
  logic act_reject;
  logic act_sts_ff;

  always_comb begin
    if ({1'h0, act_cnt_ff} >= ACT_NOM_W) begin
      act_dev = {1'h0, act_cnt_ff} - ACT_NOM_W;
    end else begin
      act_dev = ACT_NOM_W - {1'h0, act_cnt_ff};
    end
  end

  assign act_accept = act_tick && act_armed_ff && (act_dev <= ACT_ACC_W);
  assign act_reject = act_tick && act_armed_ff && (act_dev > ACT_REJ_W);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_sts_ff <= rcm_pkg::ACT_STS_RST; // [RULE7]
    end else if (act_srst) begin
      act_sts_ff <= 1'h1;
    end else if (act_reject) begin
      act_sts_ff <= 1'h1; // [RULE17]
    end else if (act_accept) begin
      act_sts_ff <= 1'h0; // [RULE17]
    end
    // a neutral window keeps the status [RULE18]
  end

  // ****************************************************************
  // activity event: sticky, write one to clear
  // ****************************************************************
  logic act_evt_ff;

  // the live condition outranks a clear arriving in the same cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_evt_ff <= rcm_pkg::ACT_EVT_RST; // [RULE10]
    end else if (act_sts_ff) begin
      act_evt_ff <= 1'h1; // [RULE8] [RULE9]
    end else if (activity_event_clear_i) begin
      act_evt_ff <= 1'h0; // [RULE8]
    end
  end

  // ****************************************************************
  // reference validity
  // ****************************************************************
  logic ref_invalid_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ref_invalid_ff <= rcm_pkg::REF_INVALID_RST;
    end else begin
      ref_invalid_ff <= (los_sts_ff & ~los_mask) |
                        (act_sts_ff & ~act_mask); // [RULE16] [RULE11]
    end
  end

  assign loss_status_o = los_sts_ff;
  assign activity_status_o = act_sts_ff;
  assign activity_event_o = act_evt_ff;
  assign ref_invalid_o = ref_invalid_ff;

endmodule

// ===== testbench/rcm_monitor_assertions.sv
`timescale 1ns/1ps
// ****************
// port checks
// ****************
module rcm_monitor_assertions (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ref_clk_i,
  input wire logic [31:0] loss_nominal_config_i,
  input wire logic [15:0] loss_window_config_i,
  input wire logic [31:0] activity_window_config_i,
  input wire logic activity_unit0_soft_reset_i,
  input wire logic activity_event_clear_i,
  input wire logic loss_status_o,
  input wire logic activity_status_o,
  input wire logic activity_event_o,
  input wire logic ref_invalid_o
);
  logic ref_q_ff;
  logic [7:0] since_ff;
  logic nom_zero;
  assign nom_zero = loss_nominal_config_i[12:0] == 13'h0000;
  // saturates so a long quiet spell never looks like a fresh edge
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ref_q_ff <= 1'h0;
      since_ff <= 8'hFF;
    end else begin
      ref_q_ff <= ref_clk_i;
      if (ref_clk_i && !ref_q_ff) since_ff <= 8'h00;
      else if (since_ff != 8'hFF) since_ff <= since_ff + 8'h01;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  AST_EVT_SET: assert property (
    activity_status_o |=> activity_event_o)
    else $error("event low while disqualified");
  AST_EVT_HOLD: assert property (
    activity_event_o && !activity_event_clear_i |=> activity_event_o)
    else $error("event dropped without clear");
  AST_CLR_BLOCKED: assert property (
    $fell(activity_event_o) |->
      !$past(activity_status_o) && $past(activity_event_clear_i))
    else $error("event cleared while disqualified");
  AST_LOS_OFF: assert property (
    nom_zero [*3] |-> loss_status_o)
    else $error("loss status low with zero nominal");
  AST_INVALID: assert property (
    ref_invalid_o ==
      (($past(loss_status_o) && !$past(loss_window_config_i[0])) ||
      ($past(activity_status_o) && !$past(activity_window_config_i[20]))))
    else $error("invalid flag mismatch");
  AST_LOS_AT_TICK: assert property (
    $changed(loss_status_o) && !$past(nom_zero) && !$past(nom_zero, 2)
      |-> since_ff <= 8'h04)
    else $error("loss status moved off a window end");
  AST_ACT_AT_TICK: assert property (
    $changed(activity_status_o) && !$past(activity_unit0_soft_reset_i) &&
      !$past(activity_unit0_soft_reset_i, 2) |-> since_ff <= 8'h04)
    else $error("activity status moved off a window end");
  AST_SRST: assert property (
    activity_unit0_soft_reset_i [*2] |-> activity_status_o)
    else $error("status low during soft reset");
endmodule

bind rcm_monitor rcm_monitor_assertions rcm_monitor_assertions_i (
  .clk_i, .nrst_i, .ref_clk_i, .loss_nominal_config_i,
  .loss_window_config_i, .activity_window_config_i,
  .activity_unit0_soft_reset_i, .activity_event_clear_i, .loss_status_o,
  .activity_status_o, .activity_event_o, .ref_invalid_o);

// ===== testbench/rcm_ref_clk_model.sv
`timescale 1ns/1ps
// ****************
// monitored clock
// ****************
module rcm_ref_clk_model (
  input wire logic run_i,
  input wire logic [15:0] half_ns_i,
  output logic ref_clk_o
);
  initial begin
    ref_clk_o = 1'h0;
    // phase offset keeps edges away from the system clock edge
    #3;
    forever begin
      // a stopped oscillator sits low
      if (run_i) ref_clk_o = !ref_clk_o;
      else ref_clk_o = 1'h0;
      #(half_ns_i);
    end
  end
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
// ****************
// bench
// ****************
module testbench;
  logic clk, nrst, srst, clr, run, ref_clk, los, act, evt, inv, el, m;
  logic [31:0] thr, nom, awin;
  logic [15:0] lwin, half;
  logic [7:0] qual, lfsr;
  int bad_count, checks_done, k, nv, av, rv;
  rcm_ref_clk_model rcm_ref_clk_model_i (.run_i(run), .half_ns_i(half),
    .ref_clk_o(ref_clk));
  rcm_monitor #(.ACT_NOM(40), .ACT_ACC(2), .ACT_REJ(8)) rcm_monitor_i (
    .clk_i(clk), .nrst_i(nrst), .ref_clk_i(ref_clk),
    .loss_threshold_config_i(thr), .loss_nominal_config_i(nom),
    .loss_qualify_config_i(qual), .loss_window_config_i(lwin),
    .activity_window_config_i(awin), .activity_unit0_soft_reset_i(srst),
    .activity_event_clear_i(clr), .loss_status_o(los),
    .activity_status_o(act), .activity_event_o(evt), .ref_invalid_o(inv));
  function automatic logic [7:0] nxt_rand(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // window count is always 40 here, so only the nominal moves
  function automatic logic judge(input int n, a, r, input logic prev);
    int d;
    d = (n > 40) ? n - 40 : 40 - n;
    if (d > r) return 1'h1;
    if (d <= a) return 1'h0;
    return prev;
  endfunction
  task finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %b want %b", $time, got, exp);
    end
  endtask
  task wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // returns on the edge where the design sees a ref rise
  task align();
    int n;
    n = 0;
    while (ref_clk === 1'h1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    while (ref_clk !== 1'h1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      bad_count++;
      finish_test();
    end
  endtask
  task pulse_clr();
    clr <= 1'h1;
    @(posedge clk);
    clr <= 1'h0;
    wait_cyc(1);
  endtask
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    {nrst, srst, clr, run, thr, nom, awin, lwin, qual} = '0;
    half = 16'h00C8;
    lfsr = 8'h40;
    bad_count = 0;
    checks_done = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'h1;
    wait_cyc(1);
    chk(los, 1'h1);
    chk(act, 1'h1);
    chk(evt, 1'h1);
    chk(inv, 1'h1);
    thr <= 32'h0000_0002;
    nom <= 32'h0000_0028;
    lwin <= 16'h0008;
    run <= 1'h1;
    wait_cyc(200);
    chk(los, 1'h0);
    chk(act, 1'h0);
    chk(evt, 1'h1);
    chk(inv, 1'h0);
    pulse_clr();
    chk(evt, 1'h0);
    el = 1'h0;
    for (k = 0; k < 10; k++) begin
      lfsr = nxt_rand(lfsr);
      nv = 36 + lfsr % 9;
      lfsr = nxt_rand(lfsr);
      av = lfsr % 3;
      rv = av + lfsr[7:6];
      m = lfsr[0];
      el = judge(nv, av, rv, el);
      nom <= 32'(nv);
      thr <= (32'(av) << 16) | 32'(rv);
      lwin <= 16'h0008 | 16'(m);
      wait_cyc(130);
      chk(los, el);
      chk(inv, el & !m);
    end
    nom <= 32'h0000_0028;
    thr <= 32'h0000_0002;
    lwin <= 16'h0008;
    wait_cyc(130);
    qual <= 8'h32;
    align();
    nom <= 32'h0000_002C;
    wait_cyc(60);
    chk(los, 1'h0);
    wait_cyc(40);
    chk(los, 1'h1);
    align();
    nom <= 32'h0000_0028;
    wait_cyc(100);
    chk(los, 1'h1);
    wait_cyc(40);
    chk(los, 1'h0);
    qual <= 8'h00;
    half <= 16'h0064;
    lwin <= 16'h0010;
    awin <= 32'h0000_0002;
    wait_cyc(250);
    chk(los, 1'h0);
    chk(act, 1'h0);
    half <= 16'h012C;
    lwin <= 16'h0008;
    awin <= 32'h0000_0000;
    nom <= 32'h0000_003C;
    wait_cyc(300);
    chk(los, 1'h0);
    chk(act, 1'h1);
    chk(evt, 1'h1);
    chk(inv, 1'h1);
    pulse_clr();
    chk(evt, 1'h1);
    awin <= 32'h0010_0000;
    wait_cyc(3);
    chk(inv, 1'h0);
    chk(act, 1'h1);
    half <= 16'h00C8;
    nom <= 32'h0000_0028;
    awin <= 32'h0000_0000;
    wait_cyc(200);
    chk(act, 1'h0);
    pulse_clr();
    chk(evt, 1'h0);
    srst <= 1'h1;
    wait_cyc(3);
    chk(act, 1'h1);
    chk(evt, 1'h1);
    srst <= 1'h0;
    wait_cyc(200);
    chk(act, 1'h0);
    // 45-cycle windows sit between the activity accept and reject margins
    half <= 16'h00E1;
    nom <= 32'h0000_002D;
    wait_cyc(200);
    chk(act, 1'h0);
    chk(los, 1'h0);
    lwin <= 16'h0009;
    nom <= 32'h0000_0000;
    wait_cyc(3);
    chk(los, 1'h1);
    chk(inv, 1'h0);
    finish_test();
  end
endmodule
